// ### ulc_consts.svh
// constants for the uart line control block
`ifndef ULC_CONSTS_SVH
`define ULC_CONSTS_SVH

// register offsets on the plain register port
`define ULC_ADDR_W          12
`define ULC_OFS_BREAK       12'h00A
`define ULC_OFS_TURN        12'h00B
`define ULC_OFS_PINFN       12'h00C

// reset values
`define ULC_RST_BREAK       16'h0000
`define ULC_RST_TURN        4'h0
`define ULC_RST_PINFN       10'h300

// break duration codes
`define ULC_BRK_FOREVER     16'hFFFF
`define ULC_BRK_STOP        16'h0000

// field positions inside the pin function and turnaround registers
`define ULC_FN_RXT_BIT      9
`define ULC_FN_TXT_BIT      8
`define ULC_FN_CLK_BIT      7
`define ULC_FN_ROLE_HI      6
`define ULC_FN_ROLE_LO      5
`define ULC_FN_ALT_BIT      4
`define ULC_FN_POL_BIT      3
`define ULC_FN_MODE_HI      2
`define ULC_FN_MODE_LO      0
`define ULC_TURN_HI         3
`define ULC_FN_HI           9

// low mode field codes
`define ULC_MODE_GPIO       3'h0
`define ULC_MODE_RTS_CTS    3'h1
`define ULC_MODE_DTR_DSR    3'h2
`define ULC_MODE_DIR_TX     3'h3
`define ULC_MODE_DIR_MATCH  3'h4

// alternate direction pin role codes
`define ULC_ROLE_GPIO       2'h0
`define ULC_ROLE_DIR_TX     2'h1
`define ULC_ROLE_DIR_MATCH  2'h2

// pin indices
`define ULC_PIN_DSR         2
`define ULC_PIN_DTR         3
`define ULC_PIN_CTS         4
`define ULC_PIN_PRIM        5
`define ULC_PIN_CLK         6
`define ULC_PIN_ALT         7
`define ULC_PIN_TXT         8
`define ULC_PIN_RXT         9

// timing
`define ULC_CLK_PERIOD_NS   8
`define ULC_BRK_TICK_NS     1000000
`define ULC_MS_CYCLES       (`ULC_BRK_TICK_NS / `ULC_CLK_PERIOD_NS)

`endif

// ### ulc_pkg.sv
// types shared by the uart line control block
package ulc_pkg;

	typedef enum logic [1:0] {
		BRK_IDLE,
		BRK_WAIT_CHAR,
		BRK_SEND
	} ulc_brk_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [15:0] wdata;
	} ulc_req_s;

	// same bit order as the pin function register, bit 9 first
	typedef struct packed {
		logic       rx_tgl;
		logic       tx_tgl;
		logic       clk_en;
		logic [1:0] alt_role;
		logic       alt_pin;
		logic       pol_high;
		logic [2:0] mode;
	} ulc_pinfn_s;

	typedef struct packed {
		logic [9:0] out;
		logic [9:0] oe;
	} ulc_pins_s;

	typedef struct packed {
		logic rx_tgl;
		logic tx_tgl;
		logic clk;
		logic rts_n;
		logic dtr_n;
		logic addr_match;
	} ulc_alt_s;

endpackage

// ### ulc_dncnt.sv
// loadable down-counter used for the break duration
`timescale 1ns/1ps
module ulc_dncnt #(
	parameter int W = 16
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         dec,
	output logic      [W-1:0] val,
	output logic              zero
);

	generate
		if (W < 2) begin : g_chk
			$error("ulc_dncnt needs at least two bits");
		end
	endgenerate

	logic [W-1:0] val_r;

	// load wins over a decrement in the same cycle
	always_ff @(posedge mclk) begin
		if (!rst_n)
			val_r <= '0;
		else if (ce) begin
			if (load)
				val_r <= load_val;
			else if (dec && val_r != '0)
				val_r <= val_r - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign val  = val_r;
	assign zero = (val_r == '0);

endmodule // ulc_dncnt

// ### ulc_dir_en.sv
// direction enable hold with bit-time turnaround delay
`timescale 1ns/1ps
module ulc_dir_en #(
	parameter int DW = 4
) (
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic          tx_active,
	input  wire logic          bit_tick,
	input  wire logic [DW-1:0] delay,
	output logic               dir_tx
);

	generate
		if (DW < 1) begin : g_chk
			$error("ulc_dir_en needs a delay field");
		end
	endgenerate

	logic [DW-1:0] hold_r;
	logic          dir_tx_r;

	// reloaded every cycle of the frame, so counting starts after stop bit
	always_ff @(posedge mclk) begin
		if (!rst_n)
			hold_r <= '0;
		else if (ce) begin
			if (tx_active)
				hold_r <= delay;
			else if (bit_tick && hold_r != '0)
				hold_r <= hold_r - {{(DW-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			dir_tx_r <= 1'b0;
		else if (ce)
			dir_tx_r <= tx_active | (hold_r != '0);
	end

	assign dir_tx = dir_tx_r;

endmodule // ulc_dir_en

// ### ulc_line_ctrl.sv
// uart break, turnaround and pin function control
`timescale 1ns/1ps
`include "ulc_consts.svh"

module ulc_line_ctrl import ulc_pkg::*; #(
	parameter int MS_CYCLES = `ULC_MS_CYCLES,
	parameter int BRK_W     = 16,
	parameter int TURN_W    = 4
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  ulc_req_s         req,
	output logic      [15:0] rdata,
	input  wire logic        tx_busy,
	input  wire logic        tx_active,
	input  wire logic        bit_tick,
	output logic             tx_break,
	output logic             tx_hold,
	input  ulc_alt_s         alt,
	input  ulc_pins_s        gpio_sw,
	input  wire logic  [9:0] gpio_in,
	output ulc_pins_s        pins,
	output logic       [9:0] pin_alt,
	output logic             cts_n,
	output logic             dsr_n
);

	localparam int MS_W = $clog2(MS_CYCLES);

	generate
		if (MS_CYCLES < 2) begin : g_chk_ms
			$error("ulc_line_ctrl needs MS_CYCLES of at least 2");
		end
		if (BRK_W != 16) begin : g_chk_brk
			$error("ulc_line_ctrl break register is 16 bits");
		end
		if (TURN_W != `ULC_TURN_HI + 1) begin : g_chk_turn
			$error("ulc_line_ctrl turnaround field is 4 bits");
		end
	endgenerate

	// register port decode

	logic wr_break;
	logic wr_turn;
	logic wr_pinfn;

	assign wr_break = req.wr && (req.addr == `ULC_OFS_BREAK);
	assign wr_turn  = req.wr && (req.addr == `ULC_OFS_TURN);
	assign wr_pinfn = req.wr && (req.addr == `ULC_OFS_PINFN);

	// configuration registers

	logic       [TURN_W-1:0] turn_r;
	ulc_pinfn_s              pinfn_r;

	always_ff @(posedge mclk) begin
		if (!rst_n)
			turn_r <= `ULC_RST_TURN;
		else if (ce && wr_turn)
			turn_r <= req.wdata[`ULC_TURN_HI:0];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			pinfn_r <= ulc_pinfn_s'(`ULC_RST_PINFN);
		else if (ce && wr_pinfn)
			pinfn_r <= ulc_pinfn_s'(req.wdata[`ULC_FN_HI:0]);
	end

	// millisecond tick from the core clock

	logic [MS_W-1:0] ms_cnt_r;
	logic            ms_tick;

	assign ms_tick = (ms_cnt_r == MS_W'(MS_CYCLES - 1));

	// restart on a duration write so the first step is a full millisecond
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ms_cnt_r <= '0;
		else if (ce) begin
			if (wr_break || ms_tick)
				ms_cnt_r <= '0;
			else
				ms_cnt_r <= ms_cnt_r + MS_W'(1);
		end
	end

	// break duration counter

	logic [BRK_W-1:0] brk_val;
	logic             brk_zero;
	logic             brk_forever;
	logic             brk_dec;
	ulc_brk_e         brk_st_r;

	assign brk_forever = (brk_val == `ULC_BRK_FOREVER);
	// counting only while the line is actually in break
	assign brk_dec = ms_tick && (brk_st_r == BRK_SEND)
		&& !brk_forever;

	ulc_dncnt #(
		.W        (BRK_W)
	) u_brk_cnt (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.load     (wr_break),
		.load_val (req.wdata[BRK_W-1:0]),
		.dec      (brk_dec),
		.val      (brk_val),
		.zero     (brk_zero)
	);

	// break sequencing

	always_ff @(posedge mclk) begin
		if (!rst_n)
			brk_st_r <= BRK_IDLE;
		else if (ce) begin
			if (wr_break) begin
				if (req.wdata[BRK_W-1:0] == `ULC_BRK_STOP)
					brk_st_r <= BRK_IDLE;
				else
					brk_st_r <= BRK_WAIT_CHAR;
			end else begin
				case (brk_st_r)
					BRK_IDLE: begin
						brk_st_r <= BRK_IDLE;
					end
					BRK_WAIT_CHAR: begin
						// character finish is far below a millisecond
						if (!tx_busy)
							brk_st_r <= BRK_SEND;
					end
					BRK_SEND: begin
						if (brk_zero)
							brk_st_r <= BRK_IDLE;
					end
					default: begin
						brk_st_r <= BRK_IDLE;
					end
				endcase
			end
		end
	end

	logic tx_break_r;

	always_ff @(posedge mclk) begin
		if (!rst_n)
			tx_break_r <= 1'b0;
		else if (ce)
			tx_break_r <= (brk_st_r == BRK_SEND) && !brk_zero;
	end

	assign tx_break = tx_break_r;
	// keeps the transmitter from starting a new character meanwhile
	assign tx_hold  = (brk_st_r != BRK_IDLE);

	// direction enable with turnaround

	logic dir_tx;

	ulc_dir_en #(
		.DW        (TURN_W)
	) u_dir_en (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.ce        (ce),
		.tx_active (tx_active),
		.bit_tick  (bit_tick),
		.delay     (turn_r),
		.dir_tx    (dir_tx)
	);

	logic dir_tx_lvl;
	logic dir_match_lvl;

	// enable level after polarity; clear bit means active low
	assign dir_tx_lvl    = pinfn_r.pol_high ? dir_tx : ~dir_tx;
	assign dir_match_lvl = pinfn_r.pol_high ? alt.addr_match
		: ~alt.addr_match;

	// pin function mux

	ulc_pins_s pins_nxt;
	logic [9:0] alt_nxt;
	logic       cts_nxt;
	logic       dsr_nxt;

	always_comb begin
		pins_nxt = gpio_sw;
		alt_nxt  = '0;
		cts_nxt  = 1'b1;
		dsr_nxt  = 1'b1;
		if (pinfn_r.rx_tgl) begin
			pins_nxt.out[`ULC_PIN_RXT] = alt.rx_tgl;
			pins_nxt.oe[`ULC_PIN_RXT]  = 1'b1;
			alt_nxt[`ULC_PIN_RXT]      = 1'b1;
		end
		if (pinfn_r.tx_tgl) begin
			pins_nxt.out[`ULC_PIN_TXT] = alt.tx_tgl;
			pins_nxt.oe[`ULC_PIN_TXT]  = 1'b1;
			alt_nxt[`ULC_PIN_TXT]      = 1'b1;
		end
		if (pinfn_r.clk_en) begin
			pins_nxt.out[`ULC_PIN_CLK] = alt.clk;
			pins_nxt.oe[`ULC_PIN_CLK]  = 1'b1;
			alt_nxt[`ULC_PIN_CLK]      = 1'b1;
		end
		// alternate pin only acts when selected; reserved role stays gpio
		if (pinfn_r.alt_pin) begin
			case (pinfn_r.alt_role)
				`ULC_ROLE_DIR_TX: begin
					pins_nxt.out[`ULC_PIN_ALT] = dir_tx_lvl;
					pins_nxt.oe[`ULC_PIN_ALT]  = 1'b1;
					alt_nxt[`ULC_PIN_ALT]      = 1'b1;
				end
				`ULC_ROLE_DIR_MATCH: begin
					pins_nxt.out[`ULC_PIN_ALT] = dir_match_lvl;
					pins_nxt.oe[`ULC_PIN_ALT]  = 1'b1;
					alt_nxt[`ULC_PIN_ALT]      = 1'b1;
				end
				default: begin
					alt_nxt[`ULC_PIN_ALT] = 1'b0;
				end
			endcase
		end
		// reserved mode codes leave the modem pins as gpio
		case (pinfn_r.mode)
			`ULC_MODE_RTS_CTS: begin
				pins_nxt.out[`ULC_PIN_PRIM] = alt.rts_n;
				pins_nxt.oe[`ULC_PIN_PRIM]  = 1'b1;
				pins_nxt.oe[`ULC_PIN_CTS]   = 1'b0;
				alt_nxt[`ULC_PIN_PRIM]      = 1'b1;
				alt_nxt[`ULC_PIN_CTS]       = 1'b1;
				cts_nxt = gpio_in[`ULC_PIN_CTS];
			end
			`ULC_MODE_DTR_DSR: begin
				pins_nxt.out[`ULC_PIN_DTR] = alt.dtr_n;
				pins_nxt.oe[`ULC_PIN_DTR]  = 1'b1;
				pins_nxt.oe[`ULC_PIN_DSR]  = 1'b0;
				alt_nxt[`ULC_PIN_DTR]      = 1'b1;
				alt_nxt[`ULC_PIN_DSR]      = 1'b1;
				dsr_nxt = gpio_in[`ULC_PIN_DSR];
			end
			`ULC_MODE_DIR_TX: begin
				pins_nxt.out[`ULC_PIN_PRIM] = dir_tx_lvl;
				pins_nxt.oe[`ULC_PIN_PRIM]  = 1'b1;
				alt_nxt[`ULC_PIN_PRIM]      = 1'b1;
			end
			`ULC_MODE_DIR_MATCH: begin
				pins_nxt.out[`ULC_PIN_PRIM] = dir_match_lvl;
				pins_nxt.oe[`ULC_PIN_PRIM]  = 1'b1;
				alt_nxt[`ULC_PIN_PRIM]      = 1'b1;
			end
			default: begin
				cts_nxt = 1'b1;
			end
		endcase
	end

	ulc_pins_s  pins_r;
	logic [9:0] pin_alt_r;
	logic       cts_n_r;
	logic       dsr_n_r;

	// one flop of latency on every pin, traded for glitch-free outputs
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pins_r    <= '0;
			pin_alt_r <= '0;
		end else if (ce) begin
			pins_r    <= pins_nxt;
			pin_alt_r <= alt_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cts_n_r <= 1'b1;
			dsr_n_r <= 1'b1;
		end else if (ce) begin
			cts_n_r <= cts_nxt;
			dsr_n_r <= dsr_nxt;
		end
	end

	assign pins    = pins_r;
	assign pin_alt = pin_alt_r;
	assign cts_n   = cts_n_r;
	assign dsr_n   = dsr_n_r;

	// read data, valid the cycle after the read strobe

	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;

	always_comb begin
		rdata_nxt = 16'h0000;
		case (req.addr)
			`ULC_OFS_BREAK: rdata_nxt = brk_val;
			`ULC_OFS_TURN:  rdata_nxt = {12'h000, turn_r};
			`ULC_OFS_PINFN: rdata_nxt = {6'h00, pinfn_r};
			default:        rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			rdata_r <= 16'h0000;
		else if (ce)
			rdata_r <= req.rd ? rdata_nxt : 16'h0000;
	end

	assign rdata = rdata_r;

endmodule // ulc_line_ctrl

// ### ulc_line_ctrl_chk.sv
// port assertions for the uart line control block
`timescale 1ns/1ps
`include "ulc_consts.svh"
module ulc_line_ctrl_chk import ulc_pkg::*; (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       ce,
	input ulc_req_s        req,
	input wire logic       tx_busy,
	input wire logic       tx_break,
	input wire logic       tx_hold,
	input ulc_alt_s        alt,
	input ulc_pins_s       gpio_sw,
	input ulc_pins_s       pins,
	input wire logic [9:0] pin_alt,
	input wire logic       cts_n,
	input wire logic       dsr_n
);
	logic bw;
	assign bw = ce && req.wr && req.addr == `ULC_OFS_BREAK;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	brk_hold_a: assert property (bw && req.wdata != 16'h0000 |=> tx_hold)
		else $error("break write did not hold the transmitter");
	brk_start_a: assert property (
		bw && req.wdata != 16'h0000 ##1 !tx_busy && !req.wr ##1 !req.wr
		|=> tx_break) else $error("break late on an idle line");
	brk_stop_a: assert property (
		bw && req.wdata == 16'h0000 ##1 !req.wr |-> !tx_hold ##1 !tx_break)
		else $error("break did not stop");
	char_first_a: assert property ($rose(tx_break) |-> !$past(tx_busy, 2))
		else $error("break cut into a character");
	brk_idle_a: assert property (!tx_hold && !$past(tx_hold) |-> !tx_break)
		else $error("break without a pending request");
	gpio_pass_a: assert property ($past(rst_n) |->
		(((pins.out ^ $past(gpio_sw.out)) | (pins.oe ^ $past(gpio_sw.oe)))
		& ~pin_alt) == 10'h000) else $error("gpio pin not passed through");
	tgl_out_a: assert property ($past(rst_n) && pin_alt[8] |->
		pins.oe[8] && pins.out[8] == $past(alt.tx_tgl))
		else $error("transmit toggle not on its pin");
	clk_out_a: assert property ($past(rst_n) && pin_alt[6] |->
		pins.oe[6] && pins.out[6] == $past(alt.clk))
		else $error("clock output not on its pin");
	pair_a: assert property (pin_alt[2] == pin_alt[3] && pin_alt[1:0] == 2'h0)
		else $error("handshake pair split");
	hs_idle_a: assert property ((pin_alt[4] || cts_n) && (pin_alt[2] || dsr_n))
		else $error("handshake input active while unselected");
endmodule // ulc_line_ctrl_chk

bind ulc_line_ctrl ulc_line_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce),
	.req(req), .tx_busy(tx_busy), .tx_break(tx_break), .tx_hold(tx_hold),
	.alt(alt), .gpio_sw(gpio_sw), .pins(pins), .pin_alt(pin_alt),
	.cts_n(cts_n), .dsr_n(dsr_n));

// ### ulc_xcvr_model.sv
// transmitter and line stand-in facing the line control block
`timescale 1ns/1ps
module ulc_xcvr_model #(
	parameter int BIT = 4
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic send,
	input  wire logic tx_hold,
	output logic      tx_busy,
	output logic      tx_active,
	output logic      bit_tick
);
	logic [3:0] div_r;
	logic [3:0] left_r;
	// free running baud tick, so first bit of a frame may be short
	always_ff @(posedge mclk) begin
		if (!rst_n)
			div_r <= 4'h0;
		else
			div_r <= bit_tick ? 4'h0 : div_r + 4'h1;
	end
	assign bit_tick = div_r == 4'(BIT - 1);
	// start, eight data, stop; no new frame while break pending
	always_ff @(posedge mclk) begin
		if (!rst_n)
			left_r <= 4'h0;
		else if (send && !tx_hold && left_r == 4'h0)
			left_r <= 4'hA;
		else if (bit_tick && left_r != 4'h0)
			left_r <= left_r - 4'h1;
	end
	assign tx_busy = left_r != 4'h0;
	assign tx_active = tx_busy;
endmodule // ulc_xcvr_model

// ### ulc_line_ctrl_test.sv
// self-checking bench for the uart line control block
`timescale 1ns/1ps
`include "ulc_consts.svh"
module ulc_line_ctrl_test import ulc_pkg::*; ;
	localparam int MS = 10;
	typedef struct packed {
		logic [15:0] fn;
		logic [9:0]  alt;
	} ulc_row_s;
	// only defined codes, reserved bits zero, pin 5 role distinct from pin 7
	ulc_row_s    rows [10] = '{'{16'h0300, 10'h300}, '{16'h0000, 10'h000},
		'{16'h0080, 10'h040}, '{16'h0001, 10'h030}, '{16'h0002, 10'h00C},
		'{16'h0003, 10'h020}, '{16'h0004, 10'h020}, '{16'h0040, 10'h000},
		'{16'h0034, 10'h0A0}, '{16'h0051, 10'h0B0}};
	int          dly [2] = '{0, 15};
	logic        mclk;
	logic        rst_n;
	logic        send;
	ulc_req_s    req;
	logic [15:0] rdata;
	logic        tx_busy;
	logic        tx_active;
	logic        bit_tick;
	logic        tx_break;
	logic        tx_hold;
	ulc_pins_s   pins;
	logic [9:0]  pin_alt;
	logic        cts_n;
	logic        dsr_n;
	int          num_errors = 0;
	int          checked = 0;
	int          cycles = 0;
	int          n;

	// gpio and alternate sources held constant: passthrough is still seen
	ulc_line_ctrl #(.MS_CYCLES(MS)) DUT (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
		.req(req), .rdata(rdata), .tx_busy(tx_busy), .tx_active(tx_active),
		.bit_tick(bit_tick), .tx_break(tx_break), .tx_hold(tx_hold),
		.alt(6'h2A), .gpio_sw({10'h2B5, 10'h3C3}), .gpio_in(10'h0F0),
		.pins(pins), .pin_alt(pin_alt), .cts_n(cts_n), .dsr_n(dsr_n));
	ulc_xcvr_model #(.BIT(4)) u_line (.mclk(mclk), .rst_n(rst_n), .send(send),
		.tx_hold(tx_hold), .tx_busy(tx_busy), .tx_active(tx_active),
		.bit_tick(bit_tick));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors = num_errors + 1;
			final_report();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge mclk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge mclk);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] exp);
		@(posedge mclk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge mclk);
		req.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		send = 1'b0;
		req = '0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		cyc(2);
		chk(pin_alt, 16'h0300);
		chk({cts_n, dsr_n, tx_break, tx_hold}, 16'h000C);
		rd(`ULC_OFS_BREAK, 16'h0000);
		rd(`ULC_OFS_TURN, 16'h0000);
		rd(`ULC_OFS_PINFN, 16'h0300);
		rd(12'h0FF, 16'h0000);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(`ULC_OFS_PINFN, rows[i].fn);
			rd(`ULC_OFS_PINFN, rows[i].fn);
			cyc(1);
			chk(pin_alt, rows[i].alt);
			// dsr input pin is held low, cts input pin high
			chk({cts_n, dsr_n}, (rows[i].fn[2:0] == `ULC_MODE_DTR_DSR) ? 16'h0002 : 16'h0003);
		end
		$display("test pin table done");
		wr(`ULC_OFS_BREAK, 16'h0005);
		cyc(2);
		chk(tx_break, 1'b1);
		cyc(20);
		wr(`ULC_OFS_BREAK, 16'h0002);
		rd(`ULC_OFS_BREAK, 16'h0002);
		cyc(2 * MS - 8);
		chk(tx_break, 1'b1);
		cyc(12);
		chk(tx_break, 1'b0);
		wr(`ULC_OFS_BREAK, `ULC_BRK_FOREVER);
		cyc(12 * MS);
		chk(tx_break, 1'b1);
		rd(`ULC_OFS_BREAK, `ULC_BRK_FOREVER);
		wr(`ULC_OFS_BREAK, `ULC_BRK_STOP);
		cyc(2);
		chk(tx_break, 1'b0);
		$display("test break timing done");
		send <= 1'b1;
		wr(`ULC_OFS_BREAK, 16'h0001);
		send <= 1'b0;
		cyc(2);
		chk(tx_break, 1'b0);
		while (tx_busy === 1'b1) cyc(1);
		cyc(2);
		chk(tx_break, 1'b1);
		cyc(3 * MS);
		$display("test break after char done");
		foreach (dly[k]) begin
			wr(`ULC_OFS_TURN, 16'(dly[k]));
			rd(`ULC_OFS_TURN, 16'(dly[k]));
			wr(`ULC_OFS_PINFN, 16'h000B);
			send <= 1'b1;
			cyc(4);
			send <= 1'b0;
			chk(pins.out[5], 1'b1);
			// sample settled values, never in the launching time step
			while (tx_active === 1'b1) cyc(1);
			n = 0;
			while (pins.out[5] === 1'b1 && n < 99) begin
				cyc(1);
				n = n + int'(bit_tick);
			end
			chk(16'(n), 16'(dly[k]));
		end
		wr(`ULC_OFS_PINFN, 16'h0003);
		send <= 1'b1;
		cyc(4);
		send <= 1'b0;
		chk(pins.out[5], 1'b0);
		cyc(120);
		chk(pins.out[5], 1'b1);
		$display("test direction done");
		final_report();
	end
endmodule // ulc_line_ctrl_test
